// ### src/pcc_top.sv
/*
  Card-side attribute-memory slave: function configuration registers and
  the path to the external card information EEPROM, in four build variants.
  Assumes host strobes are asynchronous and are synchronised here; the host
  keeps address, selects and data stable for the whole strobe.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - The full variant keeps four configuration registers as raw bits for outside logic.
// R2 - Registers sit at attribute addresses 100h, 102h, 104h, 106h, decoded only with attribute select and card select.
// R3 - The host can write each register and reads back the last value written.
// R4 - No register bit is interpreted or triggers anything inside the block.
// R5 - Other attribute accesses go to the EEPROM so the host can read and write it.
// R6 - EEPROM accesses assert the EEPROM chip select plus its output enable or write enable.
// R7 - The test variant drives out bits 7-2 of reg 0, 7-1 of reg 1, 7-0 of reg 2, 2-0 of reg 3.
// R8 - The single-register variant has register 0 only and no EEPROM path or chip select; here the ROM_CS_N pin is still kept and held high.
// R9 - The four-register variant has all four registers, no EEPROM path, but keeps the chip select pin.
// R10 - The host interface is a 16-bit address and 8-bit data qualified by four strobes.
// R11 - The block asserts wait to the host until the EEPROM access is complete.
// R12 - The transceiver direction points to the host in card reads and to the card otherwise.
// R13 - The host holds selects and address stable over the strobe and stretches it during wait.
// R14 - Host data is driven only while card select and read strobe are active on a selected address.
module pcc_top #(
  parameter logic [1:0] VARIANT = pcc_pkg::PCC_VAR_FULL
) (
  input wire logic REF_CLK, // 25 MHz reference clock
  input wire logic ARST_N, // Asynchronous reset, active low
  input wire logic CLK_EN, // Clock enable, freezes all state but the reset synchroniser when low
  input wire logic [15:0] HOST_ADDR, // Host address
  input wire logic [7:0] HOST_DATA_I, // Host data in
  output logic [7:0] HOST_DATA_O, // Host data out
  output logic HOST_DATA_OE, // Host data drive enable
  input wire logic CARD_SELECT_LOW_BYTE_N, // Card enable, active low
  input wire logic ATTR_SELECT_N, // Attribute memory select, active low
  input wire logic HOST_READ_STROBE_N, // Output enable from host, active low
  input wire logic HOST_WRITE_STROBE_N, // Write enable from host, active low
  output logic HOST_WAIT_N, // Wait to host, active low
  output logic BUF_DIR, // Transceiver direction, high toward host
  output logic ROM_CS_N, // EEPROM chip select, active low
  output logic ROM_OE_N, // EEPROM output enable, active low
  output logic ROM_WE_N, // EEPROM write enable, active low
  output logic [15:0] ROM_ADDR, // EEPROM address
  input wire logic [7:0] ROM_DATA_I, // EEPROM data in
  output logic [7:0] ROM_DATA_O, // EEPROM data out
  output logic ROM_DATA_OE, // EEPROM data drive enable
  output logic [7:0] CFG0_Q, // Register 0 raw bits
  output logic [7:0] CFG1_Q, // Register 1 raw bits
  output logic [7:0] CFG2_Q, // Register 2 raw bits
  output logic [7:0] CFG3_Q, // Register 3 raw bits
  output logic [5:0] TEST_CFG0_BITS, // Register 0 bits 7-2, test variant
  output logic [6:0] TEST_CFG1_BITS, // Register 1 bits 7-1, test variant
  output logic [7:0] TEST_CFG2_BITS, // Register 2 bits 7-0, test variant
  output logic [2:0] TEST_CFG3_BITS // Register 3 bits 2-0, test variant
);
  import pcc_pkg::*;

  // Variant properties fixed at elaboration
  localparam bit HAS_ROM = (VARIANT == PCC_VAR_FULL) || (VARIANT == PCC_VAR_TEST); // R8 R9
  localparam int NUM_REGS = (VARIANT == PCC_VAR_SINGLE) ? 1 : PCC_NUM_CFG; // R1 R8 R9
  localparam logic [PCC_CNT_W-1:0] RD_LOAD = PCC_CNT_W'(PCC_ROM_RD_CYC - 1);
  localparam logic [PCC_CNT_W-1:0] WR_LOAD = PCC_CNT_W'(PCC_ROM_WR_CYC - 1);

  // Reset release synchroniser; both flops take only constants on reset
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Synchronised pins
  logic [15:0] addr_s;
  logic [7:0] hdata_s;
  logic [7:0] rdata_s;
  logic [3:0] strb_s;
  logic ce_n_s;
  logic attr_n_s;
  logic oe_n_s;
  logic we_n_s;

  pcc_sync #(.W(16), .INIT(16'h0000)) u_sync_addr (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .en(CLK_EN),
    .d(HOST_ADDR),
    .q(addr_s)
  );

  pcc_sync #(.W(8), .INIT(8'h00)) u_sync_hdata (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .en(CLK_EN),
    .d(HOST_DATA_I),
    .q(hdata_s)
  );

  pcc_sync #(.W(8), .INIT(8'h00)) u_sync_rdata (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .en(CLK_EN),
    .d(ROM_DATA_I),
    .q(rdata_s)
  );

  // Strobes rest inactive (high) out of reset
  pcc_sync #(.W(4), .INIT(4'hF)) u_sync_strb (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .en(CLK_EN),
    .d({CARD_SELECT_LOW_BYTE_N, ATTR_SELECT_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N}),
    .q(strb_s)
  );

  assign ce_n_s = strb_s[3];
  assign attr_n_s = strb_s[2];
  assign oe_n_s = strb_s[1];
  assign we_n_s = strb_s[0];

  // Register storage
  logic [PCC_NUM_CFG*8-1:0] cfg_words;
  pcc_core_t q;
  pcc_core_t d;

  pcc_cfg_bank #(.N(NUM_REGS)) u_bank (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .en(CLK_EN),
    .we(q.cfg_we),
    .idx(q.cfg_idx),
    .wdata(q.cfg_wdata),
    .words(cfg_words)
  );

  // Attribute cycle qualification and register address decode
  logic attr_acc;
  logic rd_req;
  logic wr_req;
  logic cfg_hit;
  logic [1:0] cfg_sel;

  always_comb begin
    attr_acc = !ce_n_s && !attr_n_s; // R2 R10
    rd_req = attr_acc && !oe_n_s;
    wr_req = attr_acc && !we_n_s;
    cfg_hit = 1'b0;
    cfg_sel = 2'h0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (addr_s == PCC_CFG_OFFSET[i]) begin
        cfg_hit = 1'b1; // R2
        cfg_sel = 2'(i);
      end
    end
  end

  // Controller next state
  always_comb begin
    d = q;
    d.cfg_we = 1'b0;
    case (q.st)
      PCC_IDLE: begin
        d.wait_n = 1'b1;
        if (rd_req || wr_req) begin
          d.rd = rd_req;
          d.st = PCC_HOLD;
          if (cfg_hit) begin
            if (wr_req) begin
              d.cfg_we = 1'b1; // R3
              d.cfg_idx = cfg_sel;
              d.cfg_wdata = hdata_s;
            end else begin
              d.host_dout = cfg_words[cfg_sel*8 +: 8]; // R3
              d.host_doe = 1'b1; // R14
              d.buf_dir = 1'b1; // R12
            end
          end else if (HAS_ROM) begin
            // Unmapped attribute space belongs to the EEPROM
            d.st = PCC_ROM; // R5
            d.rom_cs_n = 1'b0; // R6
            d.rom_oe_n = !rd_req; // R6
            d.rom_we_n = rd_req; // R6
            d.rom_addr = addr_s;
            d.rom_dout = hdata_s;
            d.rom_doe = !rd_req;
            d.wait_n = 1'b0; // R11
            d.buf_dir = rd_req; // R12
            d.cnt = rd_req ? RD_LOAD : WR_LOAD;
          end
        end
      end
      PCC_ROM: begin
        if (!(rd_req || wr_req)) begin
          // Host gave up early; end the EEPROM strobe cleanly
          d.st = PCC_IDLE;
          d.rom_cs_n = 1'b1;
          d.rom_oe_n = 1'b1;
          d.rom_we_n = 1'b1;
          d.rom_doe = 1'b0;
          d.wait_n = 1'b1;
          d.buf_dir = 1'b0;
        end else if (q.cnt == '0) begin
          d.st = PCC_HOLD;
          d.rom_cs_n = 1'b1;
          d.rom_oe_n = 1'b1;
          d.rom_we_n = 1'b1;
          d.rom_doe = 1'b0;
          d.wait_n = 1'b1; // R11
          if (q.rd) begin
            d.host_dout = rdata_s;
            d.host_doe = 1'b1; // R14
          end
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      PCC_HOLD: begin
        // Wait for the host to end the cycle (R13); data is released with it
        if (!(rd_req || wr_req)) begin
          d.st = PCC_IDLE;
          d.host_doe = 1'b0; // R14
          d.buf_dir = 1'b0; // R12
        end
      end
      default: begin
        d.st = PCC_IDLE;
      end
    endcase
  end

  // Controller state register
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: PCC_IDLE, cnt: '0, rd: 1'b0, wait_n: 1'b1, buf_dir: 1'b0,
             rom_cs_n: 1'b1, rom_oe_n: 1'b1, rom_we_n: 1'b1, rom_addr: 16'h0000,
             rom_dout: 8'h00, rom_doe: 1'b0, host_dout: 8'h00, host_doe: 1'b0,
             cfg_we: 1'b0, cfg_idx: 2'h0, cfg_wdata: 8'h00};
    end else if (CLK_EN) begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign HOST_DATA_O = q.host_dout;
  assign HOST_DATA_OE = q.host_doe;
  assign HOST_WAIT_N = q.wait_n;
  assign BUF_DIR = q.buf_dir;
  assign ROM_CS_N = q.rom_cs_n;
  assign ROM_OE_N = q.rom_oe_n;
  assign ROM_WE_N = q.rom_we_n;
  assign ROM_ADDR = q.rom_addr;
  assign ROM_DATA_O = q.rom_dout;
  assign ROM_DATA_OE = q.rom_doe;

  // Raw register bits for user decode
  assign CFG0_Q = cfg_words[7:0]; // R1
  assign CFG1_Q = cfg_words[15:8];
  assign CFG2_Q = cfg_words[23:16];
  assign CFG3_Q = cfg_words[31:24];

  // Test taps only exist in the test variant; elsewhere they hold zero
  if (VARIANT == PCC_VAR_TEST) begin : g_test
    assign TEST_CFG0_BITS = cfg_words[7:PCC_TST0_LSB]; // R7
    assign TEST_CFG1_BITS = cfg_words[15:8+PCC_TST1_LSB]; // R7
    assign TEST_CFG2_BITS = cfg_words[23:16]; // R7
    assign TEST_CFG3_BITS = cfg_words[24+PCC_TST3_MSB:24]; // R7
  end else begin : g_notest
    assign TEST_CFG0_BITS = 6'h00;
    assign TEST_CFG1_BITS = 7'h00;
    assign TEST_CFG2_BITS = 8'h00;
    assign TEST_CFG3_BITS = 3'h0;
  end

endmodule
`default_nettype wire

// ### src/pcc_pkg.sv
/*
  Shared constants and types for the card configuration register interface:
  attribute-space offsets, variant codes, EEPROM strobe timing and core state.
  Assumes a 25 MHz reference clock and a host that holds its cycle stable.
*/
package pcc_pkg;

  // Bus widths and register count
  localparam int PCC_ADDR_W = 16;
  localparam int PCC_DATA_W = 8;
  localparam int PCC_NUM_CFG = 4;

  // Build variants
  localparam logic [1:0] PCC_VAR_FULL = 2'h0;
  localparam logic [1:0] PCC_VAR_TEST = 2'h1;
  localparam logic [1:0] PCC_VAR_SINGLE = 2'h2;
  localparam logic [1:0] PCC_VAR_QUAD = 2'h3;

  // Attribute-memory byte addresses of the configuration registers
  localparam logic [15:0] PCC_CFG_OFFSET [PCC_NUM_CFG] = '{
    16'h0100, 16'h0102, 16'h0104, 16'h0106
  };
  localparam logic [7:0] PCC_CFG_RESET = 8'h00;

  // Test-variant field positions
  localparam int PCC_TST0_LSB = 2;
  localparam int PCC_TST1_LSB = 1;
  localparam int PCC_TST3_MSB = 2;

  // Timing: clock period and EEPROM strobe widths in ns
  localparam int PCC_CLK_NS = 40;
  localparam int PCC_ROM_RD_NS = 250;
  localparam int PCC_ROM_WR_NS = 200;
  localparam int PCC_SYNC_STAGES = 2;
  // Least times round up; read adds the data synchroniser latency
  localparam int PCC_ROM_RD_CYC =
    (PCC_ROM_RD_NS + PCC_CLK_NS - 1) / PCC_CLK_NS + PCC_SYNC_STAGES;
  localparam int PCC_ROM_WR_CYC = (PCC_ROM_WR_NS + PCC_CLK_NS - 1) / PCC_CLK_NS;
  localparam int PCC_CNT_W = 4;

  typedef enum logic [1:0] {
    PCC_IDLE,
    PCC_ROM,
    PCC_HOLD
  } pcc_state_t;

  // All state of the core controller
  typedef struct packed {
    pcc_state_t st;
    logic [PCC_CNT_W-1:0] cnt;
    logic rd;
    logic wait_n;
    logic buf_dir;
    logic rom_cs_n;
    logic rom_oe_n;
    logic rom_we_n;
    logic [15:0] rom_addr;
    logic [7:0] rom_dout;
    logic rom_doe;
    logic [7:0] host_dout;
    logic host_doe;
    logic cfg_we;
    logic [1:0] cfg_idx;
    logic [7:0] cfg_wdata;
  } pcc_core_t;

endpackage

// ### src/pcc_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes multi-bit groups are held stable by the sender while sampled.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // Reference clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic en, // Clock enable
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pcc_sync_t;

  pcc_sync_t s_q;
  pcc_sync_t s_d;

  // First stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= {INIT, INIT};
    end else if (en) begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sync;

endmodule
`default_nettype wire

// ### src/pcc_cfg_bank.sv
/*
  Configuration register storage: four byte-wide entries, of which the first
  N exist; the rest read as the reset value. Bits are stored, never decoded.
  Assumes one write pulse per host write from the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_cfg_bank #(
  parameter int N = 4
) (
  input wire logic clk, // Reference clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic en, // Clock enable
  input wire logic we, // One-cycle write pulse
  input wire logic [1:0] idx, // Register index
  input wire logic [7:0] wdata, // Write data
  output logic [pcc_pkg::PCC_NUM_CFG*8-1:0] words // All entries, entry 0 lowest
);
  import pcc_pkg::*;

  // One entry per register; absent entries stay constant
  for (genvar i = 0; i < PCC_NUM_CFG; i++) begin : g_ent
    if (i < N) begin : g_real
      logic [7:0] ent_q;
      logic [7:0] ent_d;
      always_comb begin
        ent_d = ent_q;
        if (we && idx == 2'(i)) begin
          ent_d = wdata; // R3 R4
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ent_q <= PCC_CFG_RESET;
        end else if (en) begin
          ent_q <= ent_d;
        end
      end
      assign words[i*8 +: 8] = ent_q;
    end else begin : g_none
      assign words[i*8 +: 8] = PCC_CFG_RESET;
    end
  end

endmodule
`default_nettype wire

// ### testbench/pcc_top_asserts.sv
/*
  Port-level assertions for pcc_top, bound into every instance.
  Assumes CLK_EN stays high and the host holds each cycle stable.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_top_asserts #(
  parameter logic [1:0] VARIANT = pcc_pkg::PCC_VAR_FULL
) (
  input wire logic REF_CLK, // Clock
  input wire logic ARST_N, // Reset, active low
  input wire logic [15:0] HOST_ADDR, // Host address
  input wire logic [7:0] HOST_DATA_I, // Host write data
  input wire logic HOST_DATA_OE, // Host data drive
  input wire logic CARD_SELECT_LOW_BYTE_N, // Card enable
  input wire logic ATTR_SELECT_N, // Attribute select
  input wire logic HOST_READ_STROBE_N, // Read strobe
  input wire logic HOST_WRITE_STROBE_N, // Write strobe
  input wire logic HOST_WAIT_N, // Wait
  input wire logic BUF_DIR, // Transceiver direction
  input wire logic ROM_CS_N, // EEPROM select
  input wire logic ROM_OE_N, // EEPROM read enable
  input wire logic ROM_WE_N, // EEPROM write enable
  input wire logic ROM_DATA_OE, // EEPROM data drive
  input wire logic [7:0] CFG0_Q, // Register 0
  input wire logic [7:0] CFG1_Q, // Register 1
  input wire logic [7:0] CFG2_Q, // Register 2
  input wire logic [7:0] CFG3_Q, // Register 3
  input wire logic [5:0] TEST_CFG0_BITS, // Tap 0
  input wire logic [6:0] TEST_CFG1_BITS, // Tap 1
  input wire logic [7:0] TEST_CFG2_BITS, // Tap 2
  input wire logic [2:0] TEST_CFG3_BITS // Tap 3
);
  import pcc_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Pin decode; outputs lag the pins by two sync flops and one state edge
  wire sel = !CARD_SELECT_LOW_BYTE_N && !ATTR_SELECT_N;
  // Only the full and test builds reach the EEPROM; the single build answers at 100h alone
  localparam bit ROM_ON = (VARIANT == PCC_VAR_FULL) || (VARIANT == PCC_VAR_TEST);
  wire reg_hit = (HOST_ADDR[15:3] == 13'h0020) && !HOST_ADDR[0] &&
    (VARIANT != PCC_VAR_SINGLE || HOST_ADDR[2:1] == 2'h0);
  wire rd_rom = ROM_ON && sel && !reg_hit && !HOST_READ_STROBE_N;
  wire wr_rom = ROM_ON && sel && !reg_hit && !HOST_WRITE_STROBE_N;
  wire rd_reg = sel && reg_hit && !HOST_READ_STROBE_N;
  wire wr_reg0 = sel && (HOST_ADDR == 16'h0100) && !HOST_WRITE_STROBE_N;
  sequence rd_rom_s; rd_rom && $fell(HOST_READ_STROBE_N) ##1 rd_rom [*2]; endsequence
  sequence wr_rom_s; wr_rom && $fell(HOST_WRITE_STROBE_N) ##1 wr_rom [*2]; endsequence
  sequence rd_reg_s; rd_reg && $fell(HOST_READ_STROBE_N) ##1 rd_reg [*2]; endsequence
  a_rom_read_wait: assert property (rd_rom_s |-> ##2 (!HOST_WAIT_N && !ROM_CS_N && !ROM_OE_N)
    ##9 (HOST_WAIT_N && HOST_DATA_OE && BUF_DIR)) else $error("eeprom read timing wrong");
  a_rom_write_pulse: assert property (wr_rom_s |-> ##1 (!HOST_WAIT_N && !ROM_WE_N && ROM_DATA_OE)
    [*5] ##1 (HOST_WAIT_N && ROM_WE_N)) else $error("eeprom write timing wrong");
  a_reg_read_drive: assert property (rd_reg_s |-> ##2 (HOST_DATA_OE && BUF_DIR && HOST_WAIT_N))
    else $error("register read not driven");
  a_reg_write_store: assert property (wr_reg0 [*3] |-> ##2 CFG0_Q == $past(HOST_DATA_I, 2))
    else $error("register write not stored");
  a_wait_rom_only: assert property (!HOST_WAIT_N |-> !ROM_CS_N)
    else $error("wait outside eeprom access");
  a_rom_strobe_pair: assert property ((!ROM_OE_N || !ROM_WE_N) |-> !ROM_CS_N && ROM_OE_N != ROM_WE_N)
    else $error("eeprom strobes inconsistent");
  a_drive_when_sel: assert property (HOST_DATA_OE |-> BUF_DIR && $past(sel && !HOST_READ_STROBE_N, 3))
    else $error("host data driven without read");
  a_test_taps: assert property ({TEST_CFG0_BITS, TEST_CFG1_BITS, TEST_CFG2_BITS, TEST_CFG3_BITS} ==
    ((VARIANT == PCC_VAR_TEST) ? {CFG0_Q[7:2], CFG1_Q[7:1], CFG2_Q, CFG3_Q[2:0]} : 24'h000000))
    else $error("test taps wrong");
endmodule
bind pcc_top pcc_top_asserts #(.VARIANT(VARIANT)) u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .HOST_ADDR(HOST_ADDR), .HOST_DATA_I(HOST_DATA_I), .HOST_DATA_OE(HOST_DATA_OE),
  .CARD_SELECT_LOW_BYTE_N(CARD_SELECT_LOW_BYTE_N), .ATTR_SELECT_N(ATTR_SELECT_N),
  .HOST_READ_STROBE_N(HOST_READ_STROBE_N), .HOST_WRITE_STROBE_N(HOST_WRITE_STROBE_N),
  .HOST_WAIT_N(HOST_WAIT_N), .BUF_DIR(BUF_DIR), .ROM_CS_N(ROM_CS_N), .ROM_OE_N(ROM_OE_N),
  .ROM_WE_N(ROM_WE_N), .ROM_DATA_OE(ROM_DATA_OE), .CFG0_Q(CFG0_Q), .CFG1_Q(CFG1_Q),
  .CFG2_Q(CFG2_Q), .CFG3_Q(CFG3_Q), .TEST_CFG0_BITS(TEST_CFG0_BITS),
  .TEST_CFG1_BITS(TEST_CFG1_BITS), .TEST_CFG2_BITS(TEST_CFG2_BITS),
  .TEST_CFG3_BITS(TEST_CFG3_BITS));
`default_nettype wire

// ### testbench/pcc_rom_model.sv
/*
  Behavioural card-information EEPROM, 256 bytes by the low address byte.
  Assumes strobes from pcc_top on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_rom_model (
  input wire logic clk, // Clock
  input wire logic cs_n, // Chip select, active low
  input wire logic oe_n, // Read enable, active low
  input wire logic we_n, // Write enable, active low
  input wire logic [15:0] addr, // Byte address
  input wire logic [7:0] din, // Write data
  input wire logic doe, // Write data valid
  output logic [7:0] dout // Read data
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'hA5;
  // Store while the write strobe is low
  always @(posedge clk) begin
    if (!cs_n && !we_n && doe) mem[addr[7:0]] <= din;
    if (!cs_n && !oe_n) last <= mem[addr[7:0]];
  end
  // Released bus shows the inverse of the last byte, so stale data never passes
  assign dout = (!cs_n && !oe_n) ? mem[addr[7:0]] : ~last;
endmodule
`default_nettype wire

// ### testbench/pcc_top_tb_top.sv
/*
  Self-checking bench for the full variant of pcc_top with an EEPROM model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module pcc_top_tb_top;
  import pcc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] din = 8'h00;
  logic ce_n = 1'b1, at_n = 1'b1, oe_n = 1'b1, we_n = 1'b1, busy = 1'b0;
  wire [7:0] hdo, rdi, rdo, c0, c1, c2, c3, t2;
  wire [15:0] radr;
  wire [5:0] t0;
  wire [6:0] t1;
  wire [2:0] t3;
  wire hoe, hwait, dir, rcs, roe, rwe, rdoe;
  logic [7:0] q [$];
  logic [31:0] rng = 32'h76E9;
  int err_count = 0;
  int compares = 0;

  always #20 ref_clk = ~ref_clk;

  pcc_top uut (.REF_CLK(ref_clk), .ARST_N(arst_n), .CLK_EN(1'b1), .HOST_ADDR(addr),
    .HOST_DATA_I(din), .HOST_DATA_O(hdo), .HOST_DATA_OE(hoe), .CARD_SELECT_LOW_BYTE_N(ce_n),
    .ATTR_SELECT_N(at_n), .HOST_READ_STROBE_N(oe_n), .HOST_WRITE_STROBE_N(we_n),
    .HOST_WAIT_N(hwait), .BUF_DIR(dir), .ROM_CS_N(rcs), .ROM_OE_N(roe), .ROM_WE_N(rwe),
    .ROM_ADDR(radr), .ROM_DATA_I(rdi), .ROM_DATA_O(rdo), .ROM_DATA_OE(rdoe), .CFG0_Q(c0),
    .CFG1_Q(c1), .CFG2_Q(c2), .CFG3_Q(c3), .TEST_CFG0_BITS(t0), .TEST_CFG1_BITS(t1),
    .TEST_CFG2_BITS(t2), .TEST_CFG3_BITS(t3));
  pcc_rom_model u_rom (.clk(ref_clk), .cs_n(rcs), .oe_n(roe), .we_n(rwe), .addr(radr),
    .din(rdo), .doe(rdoe), .dout(rdi));
  // Test build on the same host bus, so its taps can be held against written bytes
  wire [7:0] xt2;
  wire [5:0] xt0;
  wire [6:0] xt1;
  wire [2:0] xt3;
  pcc_top #(.VARIANT(PCC_VAR_TEST)) uut_tst (.REF_CLK(ref_clk), .ARST_N(arst_n), .CLK_EN(1'b1),
    .HOST_ADDR(addr), .HOST_DATA_I(din), .HOST_DATA_O(), .HOST_DATA_OE(),
    .CARD_SELECT_LOW_BYTE_N(ce_n), .ATTR_SELECT_N(at_n), .HOST_READ_STROBE_N(oe_n),
    .HOST_WRITE_STROBE_N(we_n), .HOST_WAIT_N(), .BUF_DIR(), .ROM_CS_N(), .ROM_OE_N(),
    .ROM_WE_N(), .ROM_ADDR(), .ROM_DATA_I(8'h00), .ROM_DATA_O(), .ROM_DATA_OE(), .CFG0_Q(),
    .CFG1_Q(), .CFG2_Q(), .CFG3_Q(), .TEST_CFG0_BITS(xt0), .TEST_CFG1_BITS(xt1),
    .TEST_CFG2_BITS(xt2), .TEST_CFG3_BITS(xt3));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("Counts: %0d mismatches, %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One host cycle, held until wait is gone and read data is up; bounded
  task automatic hcyc(input logic rd, input logic an, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    din <= d;
    ce_n <= 1'b0;
    at_n <= an;
    oe_n <= !rd;
    we_n <= rd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (n < 60 && !(n >= 5 && hwait === 1'b1 && (!rd || an || hoe === 1'b1)));
    if (n >= 60) begin
      err_count++;
      summarize();
    end
    ce_n <= 1'b1;
    at_n <= 1'b1;
    oe_n <= 1'b1;
    we_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic hrd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    hcyc(1'b1, 1'b0, a, 8'h00);
  endtask

  // Every new host drive delivers the oldest noted byte; a drive with none noted is wrong
  always @(negedge ref_clk) begin
    if (hoe === 1'b1 && !busy) begin
      busy = 1'b1;
      if (q.size() == 0) chk("spurious_drive", 16'h0001, 16'h0000);
      else chk("read_data", {8'h00, hdo}, {8'h00, q.pop_front()});
      chk("buf_dir", {15'h0000, dir}, 16'h0001);
    end else if (hoe !== 1'b1) busy = 1'b0;
  end

  initial begin
    logic [7:0] v [4];
    logic [7:0] a;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Reset contents, then random bytes into each register back to back
    for (int i = 0; i < 4; i++) hrd(PCC_CFG_OFFSET[i], 8'h00);
    chk("taps", {15'h0000, |{t0, t1, t2, t3}}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      v[i] = rng[7:0];
      hcyc(1'b0, 1'b0, PCC_CFG_OFFSET[i], v[i]);
    end
    for (int i = 0; i < 4; i++) hrd(PCC_CFG_OFFSET[i], v[i]);
    chk("cfg_low", {c1, c0}, {v[1], v[0]});
    chk("cfg_high", {c3, c2}, {v[3], v[2]});
    chk("tap01", {3'h0, xt1, xt0}, {3'h0, v[1][7:1], v[0][7:2]});
    chk("tap23", {5'h00, xt3, xt2}, {5'h00, v[3][2:0], v[2]});
    // Without attribute select a write is ignored and a read is not answered
    hcyc(1'b0, 1'b1, 16'h0102, ~v[1]);
    hcyc(1'b1, 1'b1, 16'h0102, 8'h00);
    hrd(16'h0102, v[1]);
    // EEPROM bytes at random addresses below the register block
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      a = rng[15:8];
      hcyc(1'b0, 1'b0, {8'h00, a}, rng[7:0]);
      hrd({8'h00, a}, rng[7:0]);
    end
    chk("pending", 16'(q.size()), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
